// >>> logic/emp_consts.svh
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH
// memory size selects the top address bit in use
`define EMP_SIZE_16K      2'h0
`define EMP_SIZE_32K      2'h1
`define EMP_SIZE_64K      2'h2
`define EMP_ENC_TOP_ADDR  16'h003f
`define EMP_LOCK_NONE     2'h0
`define EMP_LOCK_BIT1     2'h1
`define EMP_LOCK_BIT2     2'h2
`define EMP_LOCK_BIT3     2'h3
`endif

// >>> logic/emp_mode_entry.sv
`timescale 1ns/10ps
`include "emp_consts.svh"
// Behaviour
// R1: host drives strobe low during reset
// R2: emulation entered if strobe low at release
// R3: emulation held until next ordinary reset
// R4: emulation: pins weak pulled, port0 floats
// R5: emulator drives board while device released
// R6: programmer holds pins steady during operation
// R7: address from p1, p2[5:0], p3[5:4]
// R8: data passes on port 0 bits 0-7
// R9: program code mode pin decode
// R10: verify code mode, byte out on port0
// R11: signature read and encryption array decode
// R12: lock bit programming and selection
// R13: decode only in reset; ignore undefined combos
module emp_mode_entry
  import emp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire emp_pins_t   i_pins,
  input  wire logic        i_ale_in,
  input  wire logic [1:0]  i_mem_size,
  input  wire logic [7:0]  i_p0_in,
  input  wire logic [7:0]  i_mem_rdata,
  input  wire logic [7:0]  i_sig_rdata,
  output logic             o_emulation,
  output logic             o_pins_release_n,
  output logic             o_p0_oe_n,
  output logic [7:0]       o_p0_out,
  output emp_req_t         o_req,
  output logic             o_mem_wr,
  output logic [7:0]       o_mem_wdata
);

  // ***************************************
  // emulation entry
  // ***************************************
  logic        emul_q;
  logic        rst_q;
  logic        ale_low_q;
  logic        rst_rise;
  logic        rst_fall;
  logic        setup_ok;
  logic        program_pulse_n_row;
  logic        read_row;
  logic        lock_row;
  logic        is_program_pulse_n;
  logic        is_read;
  logic        enc_in_range;
  logic        wr_allowed;
  logic [1:0]  top_en;
  logic [1:0]  addr_top;
  emp_mode_t   mode_d;
  logic [1:0]  lock_d;
  logic [15:0] addr_d;

  // reset pin level of the previous clock, for edge detection
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= i_pins.reset;
    end
  end

  // strobe low with program store strobe high, one clock before release
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ale_low_q <= 1'b0;
    end else begin
      ale_low_q <= !i_ale_in && i_pins.program_pulse_n_store_strobe_n; // R1
    end
  end

  // rst_q clears to 0, so a pin held high through chip reset reads as a rise, never a fall
  assign rst_rise = i_pins.reset && !rst_q;
  assign rst_fall = rst_q && !i_pins.reset;

  // entry is judged on the falling edge of reset, using the strobe seen then and the sample one clock earlier in ale_low_q
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      emul_q <= 1'b0;
    end else if (rst_rise) begin
      emul_q <= 1'b0; // R3
    end else if (rst_fall) begin
      emul_q <= ale_low_q && !i_ale_in; // R2
    end
  end

  // ***************************************
  // set-up mode decode
  // ***************************************
  // every row needs reset high and program store strobe low
  assign setup_ok = i_pins.reset && !i_pins.program_pulse_n_store_strobe_n; // R13

  // program code and encryption array rows
  assign program_pulse_n_row = setup_ok
                    && i_pins.vpp_high
                    && !i_pins.p2[6]
                    && i_pins.p2[7]
                    && i_pins.p3[3]
                    && i_pins.p3[7]; // R9 R11

  // verify and signature rows; a programming voltage on the pin rules them out
  assign read_row = setup_ok
                    && !i_pins.vpp_high
                    && i_pins.program_pulse_n
                    && i_pins.ext_access_program_pulse_n_supply
                    && !i_pins.p2[6]
                    && !i_pins.p3[3]; // R10 R11

  // lock bit rows; the bit itself is picked by three more pins
  assign lock_row = setup_ok
                    && i_pins.vpp_high
                    && i_pins.p2[6]
                    && i_pins.p3[3]; // R12

  always_comb begin
    mode_d = EMP_MODE_NONE;
    lock_d = `EMP_LOCK_NONE;
    if (program_pulse_n_row) begin
      if (i_pins.p3[6]) begin
        mode_d = EMP_MODE_PROGRAM_PULSE_N_CODE; // R9
      end else begin
        mode_d = EMP_MODE_PROGRAM_PULSE_N_ENCRYPT; // R11
      end
    end else if (read_row) begin
      if (i_pins.p3[6] && i_pins.p3[7]) begin
        mode_d = EMP_MODE_VERIFY_CODE; // R10
      end else if (!i_pins.p3[6] && !i_pins.p3[7]) begin
        mode_d = EMP_MODE_READ_SIG; // R11
      end
    end else if (lock_row) begin
      unique case ({i_pins.p2[7], i_pins.p3[6], i_pins.p3[7]}) // R12
        3'b111:  lock_d = `EMP_LOCK_BIT1;
        3'b100:  lock_d = `EMP_LOCK_BIT2;
        3'b010:  lock_d = `EMP_LOCK_BIT3;
        default: lock_d = `EMP_LOCK_NONE; // R13
      endcase
      if (lock_d != `EMP_LOCK_NONE) begin
        mode_d = EMP_MODE_PROGRAM_PULSE_N_LOCK; // R12
      end
    end
  end

  // mixed pin combinations fall through to no mode at all
  assign is_program_pulse_n = (mode_d == EMP_MODE_PROGRAM_PULSE_N_CODE)
                   || (mode_d == EMP_MODE_PROGRAM_PULSE_N_ENCRYPT)
                   || (mode_d == EMP_MODE_PROGRAM_PULSE_N_LOCK);
  assign is_read = (mode_d == EMP_MODE_VERIFY_CODE)
                   || (mode_d == EMP_MODE_READ_SIG);

  // ***************************************
  // address assembly
  // ***************************************
  // top bits count only on the larger parts; a smaller part reads them as zero
  assign top_en[0] = (i_mem_size != `EMP_SIZE_16K);
  assign top_en[1] = (i_mem_size == `EMP_SIZE_64K);

  for (genvar b = 0; b < 2; b++) begin : g_addr_top
    assign addr_top[b] = top_en[b] && i_pins.p3[4 + b]; // R7
  end

  assign addr_d = {addr_top, i_pins.p2[5:0], i_pins.p1}; // R7

  // writes into the encryption array beyond its top address are dropped from o_mem_wr; o_req.write still flags them
  assign enc_in_range = (addr_d <= `EMP_ENC_TOP_ADDR); // R11
  assign wr_allowed   = is_program_pulse_n && ((mode_d != EMP_MODE_PROGRAM_PULSE_N_ENCRYPT) || enc_in_range);

  // ***************************************
  // emulation status outputs
  // ***************************************
  // the pads keep only weak pull-ups while released
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_emulation      <= 1'b0;
      o_pins_release_n <= 1'b1;
    end else begin
      o_emulation      <= emul_q; // R5
      o_pins_release_n <= !emul_q; // R4
    end
  end

  // ***************************************
  // memory request outputs
  // ***************************************
  // levels are sampled every clock; the programmer must hold them steady
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req <= '0;
    end else begin
      o_req.mode     <= mode_d; // R6
      o_req.lock_sel <= lock_d; // R12
      o_req.addr     <= addr_d; // R7
      o_req.write    <= is_program_pulse_n && !i_pins.program_pulse_n; // R9
    end
  end

  // a write is only issued on a low program pulse
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_wr <= 1'b0;
    end else begin
      o_mem_wr <= wr_allowed && !i_pins.program_pulse_n; // R9 R11
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_wdata <= i_p0_in; // R8
    end
  end

  // ***************************************
  // port 0 outputs
  // ***************************************
  // port 0 floats in emulation and except when returning read data
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_p0_oe_n <= 1'b1;
    end else begin
      o_p0_oe_n <= emul_q || !is_read; // R4
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_p0_out <= 8'h00;
    end else begin
      o_p0_out <= (mode_d == EMP_MODE_READ_SIG) ? i_sig_rdata : i_mem_rdata; // R10
    end
  end

endmodule // emp_mode_entry

// >>> logic/emp_pkg.sv
package emp_pkg;
  typedef enum logic [2:0] {
    EMP_MODE_NONE,
    EMP_MODE_PROGRAM_PULSE_N_CODE,
    EMP_MODE_VERIFY_CODE,
    EMP_MODE_PROGRAM_PULSE_N_ENCRYPT,
    EMP_MODE_READ_SIG,
    EMP_MODE_PROGRAM_PULSE_N_LOCK
  } emp_mode_t;

  // pin levels seen by the mode decoder
  typedef struct packed {
    logic       reset;
    logic       program_pulse_n_store_strobe_n;
    logic       program_pulse_n;
    logic       vpp_high;
    logic       ext_access_program_pulse_n_supply;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } emp_pins_t;

  // one decoded memory request
  typedef struct packed {
    emp_mode_t   mode;
    logic [1:0]  lock_sel;
    logic [15:0] addr;
    logic        write;
  } emp_req_t;
endpackage

// >>> tb/emp_mode_entry_test.sv
`timescale 1ns/10ps
module emp_mode_entry_test;
  import emp_pkg::*;
  logic clk = 0, resetn = 0, rst = 0, ale = 1, pul = 0, em, rel, oe, wr;
  logic [1:0] sz = 0;
  logic [4:0] c = 0;
  logic [7:0] d = 8'ha5, po, wd;
  logic [15:0] a = 0;
  emp_pins_t pins;
  emp_req_t rq;
  int bad_count = 0, n_checks = 0;
  always #12.5 clk = !clk;
  emp_station i_emp_station (.i_rst(rst), .i_pul(pul), .i_c(c), .i_addr(a), .o_pins(pins));
  emp_mode_entry i_emp_mode_entry (.i_clk(clk), .i_resetn(resetn), .i_pins(pins), .i_ale_in(ale), .i_mem_size(sz),
    .i_p0_in(d), .i_mem_rdata(rq.addr[7:0] ^ 8'h5a), .i_sig_rdata(~rq.addr[7:0]), .o_emulation(em),
    .o_pins_release_n(rel), .o_p0_oe_n(oe), .o_p0_out(po), .o_req(rq), .o_mem_wr(wr), .o_mem_wdata(wd));
  task automatic chk(logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic t_emul;
    rst = 1;
    ale = 0;
    cyc(2);
    rst = 0;
    cyc(3);
    chk({em, rel, oe}, 3'h5);
    ale = 1;
    cyc(4);
    chk(em, 1);
    rst = 1;
    cyc(4);
    chk(em, 0);
    rst = 0;
    cyc(3);
    chk(em, 0);
    rst = 1;
    c = 5'h0b;
    ale = 0;
    cyc(2);
    rst = 0;
    cyc(3);
    chk(em, 0);
    rst = 1;
    ale = 1;
    cyc(2);
  endtask
  task automatic t_read(logic [4:0] cv, emp_mode_t m, logic [7:0] b);
    pul = 0;
    c = cv;
    a = 16'hfedc;
    for (int s = 0; s < 3; s++) begin
      sz = 2'(s);
      cyc(3);
      chk({rq.mode, oe, po}, {m, 1'b0, b});
      chk({rq.mode, rq.addr}, {m, 16'hfedc & (16'hffff >> (2 - s))});
    end
  endtask
  task automatic t_program_pulse_n(logic [4:0] cv, emp_mode_t m, logic [1:0] l);
    pul = 1;
    c = cv;
    a = 16'h003f;
    cyc(2);
    chk({rq.mode, rq.lock_sel, wr, rq.write, wd}, {m, l, 1'b1, 1'b1, d});
    a = 16'h0040;
    cyc(2);
    chk({wr, rq.write}, {m != EMP_MODE_PROGRAM_PULSE_N_ENCRYPT, 1'b1});
    pul = 0;
    cyc(2);
    chk({wr, rq.write}, 0);
  endtask
  task automatic t_undef;
    c = 5'h14;
    pul = 1;
    cyc(2);
    chk({rq.mode, wr}, 0);
    c = 5'h0f;
    rst = 0;
    cyc(2);
    chk({rq.mode, wr, oe}, 1);
  endtask
  task automatic summarize;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    cyc(5);
    resetn = 1;
    t_emul;
    t_read(5'h0b, EMP_MODE_VERIFY_CODE, 8'h86);
    t_read(5'h08, EMP_MODE_READ_SIG, 8'h23);
    t_program_pulse_n(5'h0f, EMP_MODE_PROGRAM_PULSE_N_CODE, 0);
    t_program_pulse_n(5'h0d, EMP_MODE_PROGRAM_PULSE_N_ENCRYPT, 0);
    t_program_pulse_n(5'h1f, EMP_MODE_PROGRAM_PULSE_N_LOCK, 1);
    t_program_pulse_n(5'h1c, EMP_MODE_PROGRAM_PULSE_N_LOCK, 2);
    t_program_pulse_n(5'h16, EMP_MODE_PROGRAM_PULSE_N_LOCK, 3);
    t_undef;
    summarize;
  end
  // run needs about 80 cycles; a hang is cut well past that
  initial begin
    #20000;
    bad_count++;
    summarize;
  end
endmodule // emp_mode_entry_test

// >>> tb/emp_station.sv
`timescale 1ns/10ps
module emp_station
  import emp_pkg::*;
(
  input  wire logic        i_rst,
  input  wire logic        i_pul,
  input  wire logic [4:0]  i_c,
  input  wire logic [15:0] i_addr,
  output emp_pins_t        o_pins
);
  // i_c is {p2[6],p2[7],p3[3],p3[6],p3[7]}; don't-care bits come in high
  always_comb begin
    o_pins = '0;
    o_pins.reset = i_rst;
    o_pins.program_pulse_n_store_strobe_n = i_c == 5'h00;
    o_pins.program_pulse_n = !i_pul;
    o_pins.vpp_high = i_c[2];
    o_pins.ext_access_program_pulse_n_supply = 1'b1;
    {o_pins.p2[6], o_pins.p2[7], o_pins.p3[3], o_pins.p3[6], o_pins.p3[7]} = i_c;
    {o_pins.p3[5:4], o_pins.p2[5:0], o_pins.p1} = i_addr;
  end
endmodule // emp_station

// >>> tb/emp_sva.sv
`timescale 1ns/10ps
module emp_sva
  import emp_pkg::*;
(
  input wire logic      i_clk,
  input wire logic      i_resetn,
  input wire emp_pins_t i_pins,
  input wire logic      i_ale_in,
  input wire logic      o_emulation,
  input wire logic      o_pins_release_n,
  input wire logic      o_p0_oe_n,
  input wire emp_req_t  o_req,
  input wire logic      o_mem_wr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire emp_pins_t p = i_pins;
  wire c = p.reset & !p.program_pulse_n_store_strobe_n;
  wire g = c & p.vpp_high & !p.program_pulse_n & p.p3[3];
  AST_IN: assert property ($fell(p.reset) && !i_ale_in && $past(!i_ale_in && p.program_pulse_n_store_strobe_n)
    ##1 !p.reset |=> o_emulation) else $error("no entry");
  AST_HOLD: assert property (o_emulation && !p.reset && !$past(p.reset) |=> o_emulation) else $error("left");
  AST_OUT: assert property (p.reset [*4] |-> !o_emulation) else $error("stuck");
  AST_REL: assert property (o_emulation |-> !o_pins_release_n && o_p0_oe_n) else $error("pins");
  AST_IDLE: assert property (!p.reset |=> o_req.mode == EMP_MODE_NONE && o_p0_oe_n && !o_mem_wr)
    else $error("idle");
  AST_VFY: assert property (c && p.program_pulse_n && !p.vpp_high && p.ext_access_program_pulse_n_supply && !p.p2[6]
    && !p.p3[3] && p.p3[7:6] == 2'h3 && $past(p.reset) |=> !o_p0_oe_n) else $error("vfy");
  AST_CODE: assert property (g && !p.p2[6] && p.p2[7] && p.p3[7:6] == 2'h3
    |=> o_mem_wr && o_req.mode == EMP_MODE_PROGRAM_PULSE_N_CODE) else $error("code");
  AST_LOCK: assert property (g && p.p2[6] && !p.p2[7] && p.p3[7:6] == 2'h1 |=> o_req.lock_sel == 2'h3)
    else $error("lock");
  AST_ENC: assert property (g && !p.p2[6] && p.p2[7] && p.p3[7:6] == 2'h2 && {p.p2[5:0], p.p1} > 14'h003f
    |=> !o_mem_wr) else $error("enc");
endmodule // emp_sva
bind emp_mode_entry emp_sva i_emp_sva (.*);
